// [stm_pkg.sv]
package stm_pkg;

  localparam logic [7:0] STM_OFS_CTRL0   = 8'h00;
  localparam logic [7:0] STM_OFS_CTRL1   = 8'h01;
  localparam logic [7:0] STM_OFS_CNT_LO  = 8'h02;
  localparam logic [7:0] STM_OFS_CNT_HI  = 8'h03;
  localparam logic [7:0] STM_OFS_CMPA_LO = 8'h04;
  localparam logic [7:0] STM_OFS_CMPA_HI = 8'h05;
  localparam logic [7:0] STM_OFS_STATUS  = 8'h06;

  localparam int STM_C0_PAUSE = 7;
  localparam int STM_C0_CKSEL = 4;
  localparam int STM_C0_ON    = 3;

  localparam logic [7:0] STM_RST_CTRL0 = 8'h00;
  localparam logic [7:0] STM_RST_CTRL1 = 8'h00;
  localparam logic [9:0] STM_RST_CMPA  = 10'h000;
  localparam logic [9:0] STM_CNT_MAX   = 10'h3FF;

  localparam logic [1:0] STM_MODE_CMP = 2'h0;
  localparam logic [1:0] STM_MODE_CAP = 2'h1;
  localparam logic [1:0] STM_MODE_PWM = 2'h2;
  localparam logic [1:0] STM_MODE_TMR = 2'h3;

  localparam logic [1:0] STM_PF_INACT = 2'h0;
  localparam logic [1:0] STM_PF_ACT   = 2'h1;
  localparam logic [1:0] STM_PF_PWM   = 2'h2;
  localparam logic [1:0] STM_PF_PULSE = 2'h3;

  localparam logic [1:0] STM_PF_NOCHG  = 2'h0;
  localparam logic [1:0] STM_PF_LOW    = 2'h1;
  localparam logic [1:0] STM_PF_HIGH   = 2'h2;
  localparam logic [1:0] STM_PF_TOGGLE = 2'h3;

  localparam int STM_SYS_DIV4_CNT = 4;
  localparam int STM_H_DIV16_CNT  = 16;
  localparam int STM_H_DIV64_CNT  = 64;

  typedef enum logic [1:0] {
    STM_OP_CMP,
    STM_OP_TMR,
    STM_OP_PWM,
    STM_OP_PULSE
  } stm_op_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stm_bus_s;

  typedef struct packed {
    logic [1:0] mode_sel;
    logic [1:0] pin_func;
    logic       output_level_ctrl;
    logic       output_invert;
    logic       duty_period_swap;
    logic       clear_select;
  } stm_ctrl1_s;

endpackage

// [stm_timer.sv]
// Notes on behaviour
// R1: Mode field picks compare, timer, PWM; PWM with pulse pin function is pulse
// R2: Clear-select low: clear on P or overflow
// R3: Clear-select high: clear on A, no P flag
// R4: Compare-A zero: overflow at 3FF, no A flag
// R5: Only A matches change the output pin
// R6: A match sets, clears or toggles pin
// R7: Counter-on rise loads initial pin level
// R8: Timer mode counts like compare, no pin
// R9: PWM ignores clear-select; swap bit picks roles
// R10: Period code gives 128 times code, 0 is 1024
// R11: Duty at or above period gives full duty
// R12: PWM raises A and P flags
// R13: PWM polarity, forced level and invert bits
// R14: PWM counting continues while level forced
// R15: Pulse starts on counter-on rise or pin edge
// R16: Pulse ends when counter-on clears
// R17: A match stops counter in pulse mode
// R18: Software keeps counter-on high during pulse
// R19: Counter high byte shows bits 9 and 8
// R20: Compare-A readable and writable in two bytes
// R21: Counter-on rise zeroes count; fall holds it
// R22: Pause holds count; release resumes
// R23: Comparator P looks at counter bits 9 to 7
// R24: Pulse A match clears counter-on, raises event
// R25: Counter counts ticks, wraps from 3FF to zero
`timescale 1ns/100ps
module stm_timer
  import stm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Other clock ticks
  input  wire logic       tick_h_i,
  input  wire logic       tick_tbc_i,
  // Pins
  input  wire logic       ext_clock_pin_i,
  output logic            timer_out_o,
  output logic            timer_out_en_o,
  // Events
  output logic            match_a_flag_o,
  output logic            match_p_flag_o
);

  stm_bus_s   bus;
  stm_ctrl1_s c1;
  stm_op_e    op;

  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [9:0] cmpa_ff;
  logic [9:0] cnt_ff;
  logic [9:0] nxt_cnt;
  logic       on_ff;
  logic       on_prev_ff;
  logic       pin_ff;
  logic       pwm_ff;
  logic       flag_a_ff;
  logic       flag_p_ff;
  logic       sync1_ff;
  logic       sync2_ff;
  logic       pin_prev_ff;
  logic [1:0] div4_ff;
  logic [3:0] div16_ff;
  logic [5:0] div64_ff;
  logic [7:0] rdata_ff;
  logic       out_ff;
  logic       out_en_ff;

  logic       tick;
  logic       pin_rise;
  logic       pin_fall;
  logic       on_rise;
  logic       run;
  logic       last;
  logic       match_a;
  logic       match_p;
  logic       clr_cnt;
  logic       raise_a;
  logic       raise_p;
  logic [9:0] duty;
  logic       duty_full;
  logic       wr_on;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign c1  = stm_ctrl1_s'(ctrl1_ff);

  // Mode decode
  // R1: mode decode
  always_comb begin
    unique case (c1.mode_sel)
      STM_MODE_CMP: op = STM_OP_CMP;
      STM_MODE_PWM: op = (c1.pin_func == STM_PF_PULSE) ? STM_OP_PULSE : STM_OP_PWM;
      default:      op = STM_OP_TMR;
    endcase
  end

  // External pin synchroniser and edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff    <= 1'b0;
      sync2_ff    <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      sync1_ff    <= ext_clock_pin_i;
      sync2_ff    <= sync1_ff;
      pin_prev_ff <= sync2_ff;
    end
  end
  assign pin_rise = sync2_ff & ~pin_prev_ff;
  assign pin_fall = ~sync2_ff & pin_prev_ff;

  // Internal dividers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div4_ff  <= '0;
      div16_ff <= '0;
      div64_ff <= '0;
    end else begin
      div4_ff <= div4_ff + 2'h1;
      if (tick_h_i) begin
        div16_ff <= div16_ff + 4'h1;
        div64_ff <= div64_ff + 6'h01;
      end
    end
  end

  // Clock source select
  always_comb begin
    unique case (ctrl0_ff[STM_C0_CKSEL +: 3])
      3'h0: tick = (div4_ff == 2'(STM_SYS_DIV4_CNT - 1));
      3'h1: tick = 1'b1;
      3'h2: tick = tick_h_i && (div16_ff == 4'(STM_H_DIV16_CNT - 1));
      3'h3: tick = tick_h_i && (div64_ff == 6'(STM_H_DIV64_CNT - 1));
      3'h4: tick = tick_tbc_i;
      3'h5: tick = tick_tbc_i;
      3'h6: tick = pin_rise;
      default: tick = pin_fall;
    endcase
  end

  // Comparators
  // R23: top bits compare
  // R10: last count of period
  assign match_p = run && (3'(cnt_ff[9:7] + 3'h1) == ctrl0_ff[2:0]) && (cnt_ff[6:0] == 7'h7F);
  assign match_a = run && (cnt_ff == cmpa_ff);
  assign last    = run && (cnt_ff == STM_CNT_MAX);
  assign run     = on_ff && !ctrl0_ff[STM_C0_PAUSE] && tick;

  // Clear and flag selection
  always_comb begin
    clr_cnt = 1'b0;
    raise_a = 1'b0;
    raise_p = 1'b0;
    unique case (op)
      STM_OP_CMP, STM_OP_TMR: begin
        // R8: timer shares compare counting
        if (c1.clear_select) begin
          // R3: clear on A or overflow
          // R4: zero compare never flags
          raise_a = match_a && (cmpa_ff != 10'h000);
          clr_cnt = raise_a;
        end else begin
          // R2: clear on P or overflow
          raise_a = match_a && (cmpa_ff != 10'h000);
          raise_p = match_p;
          clr_cnt = match_p;
        end
      end
      STM_OP_PWM: begin
        // R9: swap bit chooses period
        // R12: both flags in PWM
        raise_a = match_a;
        raise_p = match_p;
        clr_cnt = c1.duty_period_swap ? match_a : match_p;
      end
      STM_OP_PULSE: begin
        // R17: A match stops
        raise_a = match_a;
      end
    endcase
  end

  // Counter
  // R25: tick count and wrap
  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr_cnt || last) begin
      nxt_cnt = '0;
    end else if (run) begin
      nxt_cnt = cnt_ff + 10'h001;
    end
  end

  // R21: rise zeroes, fall holds
  // R22: pause holds count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (on_rise) begin
      cnt_ff <= '0;
    end else if (!(op == STM_OP_PULSE && raise_a)) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Counter-on bit with its triggers
  assign wr_on   = bus.wr && (bus.addr == STM_OFS_CTRL0);
  assign on_rise = on_ff && !on_prev_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_ff      <= 1'b0;
      on_prev_ff <= 1'b0;
    end else begin
      on_prev_ff <= on_ff;
      if (op == STM_OP_PULSE && raise_a) begin
        // R24: A match clears on
        on_ff <= 1'b0;
      end else if (wr_on) begin
        on_ff <= bus.wdata[STM_C0_ON];
      end else if (op == STM_OP_PULSE && !on_ff && (pin_rise || pin_fall)) begin
        // R15: pin edge starts pulse
        on_ff <= 1'b1;
      end
    end
  end

  // Control and compare registers
  // R20: compare-A byte writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl0_ff <= STM_RST_CTRL0;
      ctrl1_ff <= STM_RST_CTRL1;
      cmpa_ff  <= STM_RST_CMPA;
    end else if (bus.wr) begin
      unique case (bus.addr)
        STM_OFS_CTRL0:   ctrl0_ff <= {bus.wdata[7:4], 1'b0, bus.wdata[2:0]};
        STM_OFS_CTRL1:   ctrl1_ff <= bus.wdata;
        STM_OFS_CMPA_LO: cmpa_ff[7:0] <= bus.wdata;
        STM_OFS_CMPA_HI: cmpa_ff[9:8] <= bus.wdata[1:0];
        default:         ;
      endcase
    end
  end

  // Match flags, set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_a_ff <= 1'b0;
      flag_p_ff <= 1'b0;
    end else begin
      if (raise_a) begin
        flag_a_ff <= 1'b1;
      end else if (bus.wr && bus.addr == STM_OFS_STATUS && bus.wdata[0]) begin
        flag_a_ff <= 1'b0;
      end
      if (raise_p) begin
        flag_p_ff <= 1'b1;
      end else if (bus.wr && bus.addr == STM_OFS_STATUS && bus.wdata[1]) begin
        flag_p_ff <= 1'b0;
      end
    end
  end

  // Compare output pin state
  // R7: initial level load
  // R5: A match only
  // R6: pin function action
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_ff <= 1'b0;
    end else if (on_rise) begin
      pin_ff <= c1.output_level_ctrl;
    end else if (op == STM_OP_CMP && raise_a) begin
      unique case (c1.pin_func)
        STM_PF_LOW:    pin_ff <= 1'b0;
        STM_PF_HIGH:   pin_ff <= 1'b1;
        STM_PF_TOGGLE: pin_ff <= ~pin_ff;
        default:       pin_ff <= pin_ff;
      endcase
    end
  end

  // PWM duty tracking
  // R10: period from code
  // R11: full duty when duty too long
  assign duty      = c1.duty_period_swap ? {ctrl0_ff[2:0], 7'h00} : cmpa_ff;
  assign duty_full = c1.duty_period_swap
                   ? ((ctrl0_ff[2:0] == 3'h0) || ({ctrl0_ff[2:0], 7'h00} >= cmpa_ff))
                   : ((cmpa_ff >= {ctrl0_ff[2:0], 7'h00}) && (ctrl0_ff[2:0] != 3'h0));
  // R14: waveform keeps running
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_ff <= 1'b0;
    end else begin
      pwm_ff <= duty_full || (nxt_cnt < duty);
    end
  end

  // Output drive
  // R13: polarity and forced levels
  // R16: pulse ends with on low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_ff    <= 1'b0;
      out_en_ff <= 1'b0;
    end else begin
      out_en_ff <= (op != STM_OP_TMR);
      unique case (op)
        STM_OP_CMP:   out_ff <= pin_ff ^ c1.output_invert;
        STM_OP_PWM: begin
          unique case (c1.pin_func)
            STM_PF_INACT: out_ff <= ~c1.output_level_ctrl ^ c1.output_invert;
            STM_PF_ACT:   out_ff <= c1.output_level_ctrl ^ c1.output_invert;
            default:      out_ff <= ~(pwm_ff ^ c1.output_level_ctrl) ^ c1.output_invert;
          endcase
        end
        STM_OP_PULSE: out_ff <= ~(on_ff ^ c1.output_level_ctrl) ^ c1.output_invert;
        default:      out_ff <= 1'b0;
      endcase
    end
  end

  // Read port
  // R19: high byte layout
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        STM_OFS_CTRL0:   rdata_ff <= {ctrl0_ff[7:4], on_ff, ctrl0_ff[2:0]};
        STM_OFS_CTRL1:   rdata_ff <= ctrl1_ff;
        STM_OFS_CNT_LO:  rdata_ff <= cnt_ff[7:0];
        STM_OFS_CNT_HI:  rdata_ff <= {6'h00, cnt_ff[9:8]};
        STM_OFS_CMPA_LO: rdata_ff <= cmpa_ff[7:0];
        STM_OFS_CMPA_HI: rdata_ff <= {6'h00, cmpa_ff[9:8]};
        STM_OFS_STATUS:  rdata_ff <= {6'h00, flag_p_ff, flag_a_ff};
        default:         rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata_o        = rdata_ff;
  assign timer_out_o    = out_ff;
  assign timer_out_en_o = out_en_ff;
  assign match_a_flag_o = flag_a_ff;
  assign match_p_flag_o = flag_p_ff;

endmodule

// [stm_timer_properties.sv]
`timescale 1ns/100ps
module stm_timer_properties
  import stm_pkg::*;
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // Pins and events
  input wire logic       timer_out_o,
  input wire logic       timer_out_en_o,
  input wire logic       match_a_flag_o,
  input wire logic       match_p_flag_o
);
  stm_ctrl1_s c1_ff;
  logic       on_ff;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Shadow of mode control
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c1_ff <= '0;
    end else if (wr_i && addr_i == STM_OFS_CTRL1) begin
      c1_ff <= stm_ctrl1_s'(wdata_i);
    end
  end

  // Shadow of counter-on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_ff <= 1'h0;
    end else if (wr_i && addr_i == STM_OFS_CTRL0) begin
      on_ff <= wdata_i[STM_C0_ON];
    end
  end

  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero when idle");
  a_cnt_hi_zero: assert property (
    rd_i && addr_i == STM_OFS_CNT_HI |=> rdata_o[7:2] == 6'h00)
    else $error("counter high byte upper bits set");
  a_cmpa_hi_zero: assert property (
    rd_i && addr_i == STM_OFS_CMPA_HI |=> rdata_o[7:2] == 6'h00)
    else $error("compare high byte upper bits set");
  a_tmr_no_drive: assert property (
    (c1_ff.mode_sel == STM_MODE_TMR)[*3] |-> !timer_out_en_o)
    else $error("pin driven in timer mode");
  a_flag_a_clear: assert property (
    $fell(match_a_flag_o) |-> $past(wr_i && addr_i == STM_OFS_STATUS && wdata_i[0]))
    else $error("match flag dropped without clear");
  a_on_init_level: assert property (
    wr_i && addr_i == STM_OFS_CTRL0 && wdata_i[STM_C0_ON] && !on_ff
    && c1_ff.mode_sel == STM_MODE_CMP
    |-> ##3 timer_out_o == (c1_ff.output_level_ctrl ^ c1_ff.output_invert))
    else $error("initial level not loaded");
  a_pulse_trail: assert property (
    c1_ff.mode_sel == STM_MODE_PWM && c1_ff.pin_func == STM_PF_PULSE
    && $rose(match_a_flag_o)
    |-> ##[0:3] timer_out_o == !(c1_ff.output_level_ctrl ^ c1_ff.output_invert))
    else $error("pulse did not end on match");
  a_pwm_forced: assert property (
    (c1_ff.mode_sel == STM_MODE_PWM && c1_ff.pin_func == STM_PF_ACT && on_ff)[*3]
    |-> timer_out_o == (c1_ff.output_level_ctrl ^ c1_ff.output_invert))
    else $error("forced active level wrong");
  a_no_p_flag: assert property (
    (c1_ff.mode_sel == STM_MODE_CMP && c1_ff.clear_select)[*2]
    |-> !$rose(match_p_flag_o))
    else $error("period flag raised with clear on A");
endmodule

bind stm_timer stm_timer_properties i_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_out_o(timer_out_o),
  .timer_out_en_o(timer_out_en_o), .match_a_flag_o(match_a_flag_o),
  .match_p_flag_o(match_p_flag_o)
);

// [stm_far_side.sv]
`timescale 1ns/100ps
module stm_far_side (
  // Clock, reset and trigger request
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic fire_i,
  // Timer pins
  input  wire logic out_i,
  input  wire logic out_en_i,
  output logic      pin_o,
  output logic      level_o
);
  logic [2:0] hold_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_ff <= 3'h0;
    end else if (fire_i) begin
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end
  end
  assign pin_o = (hold_ff != 3'h0);
  // Load pulls the line low when released
  assign level_o = out_en_i ? out_i : 1'h0;
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench
  import stm_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       tick_h;
  logic       tick_tbc;
  logic       fire;
  logic [7:0] rdata;
  logic       pin;
  logic       out;
  logic       out_en;
  logic       fa;
  logic       fp;
  logic       level;
  logic [7:0] v1;
  logic [7:0] v2;
  logic [9:0] duty;
  logic [1:0] pf;
  logic       inv;
  int         mismatches;
  int         compares;
  int         test_no;

  stm_timer i_dut (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tick_h_i(tick_h), .tick_tbc_i(tick_tbc),
    .ext_clock_pin_i(pin), .timer_out_o(out), .timer_out_en_o(out_en),
    .match_a_flag_o(fa), .match_p_flag_o(fp));
  stm_far_side i_far (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .out_i(out),
    .out_en_i(out_en), .pin_o(pin), .level_o(level));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    tick_h   <= 1'($urandom);
    tick_tbc <= 1'($urandom);
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr    <= 1'h0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    #1;
    d = rdata;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic setup(input logic [7:0] c1, input logic [9:0] ca, input logic [7:0] c0);
    wr_reg(STM_OFS_CTRL0, 8'h00);
    wr_reg(STM_OFS_STATUS, 8'h03);
    wr_reg(STM_OFS_CTRL1, c1);
    wr_reg(STM_OFS_CMPA_LO, ca[7:0]);
    wr_reg(STM_OFS_CMPA_HI, {6'h00, ca[9:8]});
    wr_reg(STM_OFS_CTRL0, c0);
  endtask

  task automatic count_hi(output logic [7:0] c);
    c = 8'h00;
    repeat (128) begin
      @(posedge clk);
      #1;
      c += {7'h00, level};
    end
  endtask

  function automatic logic [7:0] exp_hi(input logic [1:0] f, input logic [9:0] d, input logic i);
    logic [7:0] a;
    a = (f == STM_PF_ACT || d >= 10'h080) ? 8'h80 : d[7:0];
    return i ? 8'h80 - a : a;
  endfunction

  task automatic done_test;
    test_no++;
    $display("test %0d finished", test_no);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {rst_n, addr, wdata, wr, rd, tick_h, tick_tbc, fire} = '0;
    {mismatches, compares, test_no} = '0;
    void'($urandom(32'hD8AE));
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    // Register map
    rd_reg(STM_OFS_CNT_HI, v1);
    check(v1, 8'h00);
    rd_reg(8'h07, v1);
    check(v1, 8'h00);
    v2 = 8'($urandom);
    wr_reg(STM_OFS_CMPA_LO, v2);
    wr_reg(STM_OFS_CMPA_HI, 8'hFF);
    wr_reg(STM_OFS_CNT_LO, 8'h55);
    rd_reg(STM_OFS_CMPA_LO, v1);
    check(v1, v2);
    rd_reg(STM_OFS_CMPA_HI, v1);
    check(v1, 8'h03);
    rd_reg(STM_OFS_CNT_LO, v1);
    check(v1, 8'h00);
    done_test();
    // Compare mode, clear on A, period below compare
    setup(8'h21, 10'h0C8, 8'h19);
    wait_cyc(5);
    check_bit(level, 1'h0);
    wait_cyc(250);
    check_bit(level, 1'h1);
    check_bit(fa, 1'h1);
    check_bit(fp, 1'h0);
    done_test();
    // Compare mode, clear on P, drive low
    setup(8'h18, 10'h028, 8'h19);
    wait_cyc(5);
    check_bit(level, 1'h1);
    wait_cyc(140);
    check_bit(level, 1'h0);
    check_bit(fa, 1'h1);
    check_bit(fp, 1'h1);
    done_test();
    // Timer mode
    setup(8'hE0, 10'h028, 8'h19);
    wait_cyc(140);
    check_bit(out_en, 1'h0);
    check_bit(fa, 1'h1);
    check_bit(fp, 1'h1);
    done_test();
    // Compare-A zero, overflow
    setup(8'h00, 10'h000, 8'h18);
    wait_cyc(1000);
    check_bit(fp, 1'h0);
    wait_cyc(100);
    check_bit(fa, 1'h0);
    check_bit(fp, 1'h1);
    done_test();
    // PWM: random duty, full duty, inverted, forced active
    for (int i = 0; i < 4; i++) begin
      duty = (i == 1) ? 10'h0C8 : 10'(1 + $urandom % 127);
      pf   = (i == 3) ? STM_PF_ACT : STM_PF_PWM;
      inv  = (i == 2);
      setup({STM_MODE_PWM, pf, 1'h1, inv, 2'h0}, duty, 8'h19);
      wait_cyc(300);
      count_hi(v1);
      check(v1, exp_hi(pf, duty, inv));
      check_bit(fp, 1'h1);
      check_bit(fa, duty < 10'h080);
    end
    done_test();
    // Single pulse from pin edge; counter-on left alone meanwhile
    setup(8'hB8, 10'h032, 8'h10);
    @(posedge clk);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
    wait_cyc(10);
    check_bit(level, 1'h1);
    wait_cyc(60);
    check_bit(level, 1'h0);
    check_bit(fa, 1'h1);
    rd_reg(STM_OFS_CTRL0, v1);
    check_bit(v1[STM_C0_ON], 1'h0);
    rd_reg(STM_OFS_CNT_LO, v1);
    wait_cyc(5);
    rd_reg(STM_OFS_CNT_LO, v2);
    check(v2, v1);
    done_test();
    // Pause and resume
    setup(8'h00, 10'h3E8, 8'h18);
    wait_cyc(20);
    wr_reg(STM_OFS_CTRL0, 8'h98);
    rd_reg(STM_OFS_CNT_LO, v1);
    wait_cyc(5);
    rd_reg(STM_OFS_CNT_LO, v2);
    check(v2, v1);
    wr_reg(STM_OFS_CTRL0, 8'h18);
    wait_cyc(5);
    rd_reg(STM_OFS_CNT_LO, v2);
    check_bit(v2 > v1, 1'h1);
    done_test();
    tally_and_finish();
  end
endmodule
